// *** shared/cfd_err_regs.svh ***
// Purpose: Register map, field positions and limits of the error-state block
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Definitions only
`ifndef CFD_ERR_REGS_SVH
`define CFD_ERR_REGS_SVH

// ----------------------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------------------
`define CFD_OFF_EVQ_HI   8'h00
`define CFD_OFF_EVQ_LO   8'h04
`define CFD_OFF_SQ_HI    8'h08
`define CFD_OFF_SQ_LO    8'h0C
`define CFD_OFF_FLAGS    8'h10
`define CFD_OFF_COUNTS   8'h14
`define CFD_OFF_FAST     8'h18
`define CFD_OFF_SLOW     8'h1C
`define CFD_OFF_MODE     8'h20
`define CFD_OFF_IRQ_STAT 8'h24
`define CFD_OFF_IRQ_EN   8'h28
`define CFD_OFF_IRQ_CLR  8'h2C

// ----------------------------------------------------------------------------
// Flag register bit positions
// ----------------------------------------------------------------------------
`define CFD_FLG_TX_BUS_OFF_FLAG  5
`define CFD_FLG_TX_ERROR_PASSIVE_FLAG  4
`define CFD_FLG_RX_ERROR_PASSIVE_FLAG  3
`define CFD_FLG_TXWRN 2
`define CFD_FLG_RXWRN 1
`define CFD_FLG_EWRN  0

// ----------------------------------------------------------------------------
// Interrupt event bit positions
// ----------------------------------------------------------------------------
`define CFD_IRQ_N      6
`define CFD_IRQ_TXWRN  0
`define CFD_IRQ_RXWRN  1
`define CFD_IRQ_TX_ERROR_PASSIVE_FLAG   2
`define CFD_IRQ_RX_ERROR_PASSIVE_FLAG   3
`define CFD_IRQ_BO     4
`define CFD_IRQ_FASTER 5

// ----------------------------------------------------------------------------
// Counter limits and steps
// ----------------------------------------------------------------------------
`define CFD_WARN_LO    9'h05F
`define CFD_WARN_HI    9'h080
`define CFD_PASSIVE    9'h07F
`define CFD_BUSOFF     9'h0FF
`define CFD_RX_REENTRY 9'h077
`define CFD_INC_MAJOR  9'h008
`define CFD_INC_MINOR  9'h001
`define CFD_CNT_MAX    9'h1FF
`define CFD_BYTE_MAX   8'hFF
`define CFD_BYTE_MAJOR 8'h08
`define CFD_BYTE_MINOR 8'h01
`define CFD_MODE_RST   3'h4
`define CFD_FLAGS_RST  6'h20

`endif

// *** shared/cfd_pkg.sv ***
// Purpose: Types shared by the error-state block
// Assumes: Constants live in cfd_err_regs.svh
// Notes:   Types only
package cfd_pkg;
  typedef logic [8:0]  cfd_cnt_t;
  typedef logic [7:0]  cfd_byte_t;
  typedef logic [31:0] cfd_word_t;
  typedef enum logic [2:0]
  {
    cfd_mode_normal = 3'h0,
    cfd_mode_config = 3'h4
  } cfd_mode_t;
endpackage

// *** verilog/cfd_fault_counter.sv ***
// Purpose: One fault-confinement error counter, nine bits wide
// Assumes: Event pulses are on the pclk domain
// Notes:   Increments win over a decrement in the same cycle
`timescale 1ns/1ps
`include "cfd_err_regs.svh"
module cfd_fault_counter
  import cfd_pkg::*;
#(
  parameter bit REENTRY_EN = 1'b0,
  parameter bit FREEZE_EN  = 1'b0
)
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Events
  input  wire logic clear,
  input  wire logic inc_minor,
  input  wire logic inc_major,
  input  wire logic dec,
  // Count
  output cfd_cnt_t  count
);

  logic [9:0] sum;
  logic       frozen;

  always_comb
  begin
    sum = {1'b0, count} + (inc_major ? {1'b0, `CFD_INC_MAJOR} : {1'b0, `CFD_INC_MINOR});
  end

  // Bus-off holds the count until recovery clears it
  assign frozen = FREEZE_EN && (count > `CFD_BUSOFF);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= '0;
    else if (clear)
      count <= '0;
    else if (frozen)
      count <= count;
    else if (inc_major || inc_minor)
      count <= sum[9] ? `CFD_CNT_MAX : sum[8:0];
    else if (dec && (count != '0))
      count <= (REENTRY_EN && (count > `CFD_PASSIVE)) ? `CFD_RX_REENTRY : count - 9'h001;
  end

endmodule // cfd_fault_counter

// *** verilog/cfd_irq_bank.sv ***
// Purpose: Sticky interrupt status, enable mask and level interrupt
// Assumes: Clear strobe comes from a completed APB write
// Notes:   A new event wins over a clear in the same cycle
`timescale 1ns/1ps
module cfd_irq_bank
#(
  parameter int N = 6
)
(
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Events
  input  wire logic [N-1:0] evt,
  // Software access
  input  wire logic         clr_wr,
  input  wire logic         en_wr,
  input  wire logic [N-1:0] wdata,
  // State
  output logic      [N-1:0] status_r,
  output logic      [N-1:0] enable_r,
  output logic              irq
);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_r <= '0;
    else
      status_r <= (status_r & ~(clr_wr ? wdata : '0)) | evt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enable_r <= '0;
    else if (en_wr)
      enable_r <= wdata;
  end

  assign irq = |(status_r & enable_r);

endmodule // cfd_irq_bank

// *** verilog/cfd_err_status.sv ***
// Purpose: Error counters, error-state flags and queue pointer readback
// Assumes: Protocol engine and queue logic run on pclk; event inputs are
//          one-cycle pulses
// Notes:   APB slave, zero wait states, error on unmapped addresses
//
// Function
// - Event queue pointer reads return tail
// - Event pointer split high and low halves
// - Send queue pointer reads return head
// - Send pointer split high and low halves
// - Bus-off flag when transmit count exceeds 255
// - Configuration state forces bus-off flag
// - Transmit passive flag above 127
// - Receive passive flag above 127
// - Transmit warning between 95 and 128
// - Receive warning between 95 and 128
// - Combined warning from either warning flag
// - Counts register: transmit high, receive low
// - Writable fast-phase error counters, reset zero
// - Writable slow-phase error counters, reset zero
// - Mode value 100 is configuration state
`timescale 1ns/1ps
`include "cfd_err_regs.svh"
module cfd_err_status
  import cfd_pkg::*;
#(
  parameter int AW = 8
)
(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic [AW-1:0] paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Protocol engine events
  input  wire logic          tx_err_pulse,
  input  wire logic          rx_err_pulse,
  input  wire logic          rx_err_major_pulse,
  input  wire logic          tx_ok_pulse,
  input  wire logic          rx_ok_pulse,
  input  wire logic          fast_phase,
  input  wire logic          recovery_done_pulse,
  // Queue pointers
  input  wire logic [31:0]   event_queue_tail_in,
  input  wire logic [31:0]   send_queue_head_in,
  // Mode and state
  output logic      [2:0]    operating_mode_select,
  output logic               tx_bus_off_flag,
  output logic               tx_error_passive_flag,
  output logic               rx_error_passive_flag,
  output logic               tx_warning_flag,
  output logic               rx_warning_flag,
  output logic               any_warning_flag,
  output logic               irq
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic cfd_byte_t sat_add8(input cfd_byte_t v, input cfd_byte_t amt);
    logic [8:0] s;
    s = {1'b0, v} + {1'b0, amt};
    return s[8] ? `CFD_BYTE_MAX : s[7:0];
  endfunction

  function automatic cfd_byte_t sat_dec8(input cfd_byte_t v);
    return (v == 8'h00) ? v : v - 8'h01;
  endfunction

  // Counts above one byte read as all ones
  function automatic cfd_byte_t clip8(input cfd_cnt_t v);
    return (v > `CFD_BUSOFF) ? `CFD_BYTE_MAX : v[7:0];
  endfunction

  function automatic logic in_warn(input cfd_cnt_t v);
    return (v > `CFD_WARN_LO) && (v < `CFD_WARN_HI);
  endfunction

  function automatic cfd_byte_t strb_byte(input cfd_byte_t old, input cfd_byte_t nw,
                                          input logic en);
    return en ? nw : old;
  endfunction

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic               setup;
  logic               wr_done;
  logic [7:0]         addr8;
  logic               mapped;
  logic [31:0]        rd_nxt;
  logic [31:0]        prdata_r;
  logic               pslverr_r;
  logic [2:0]         mode_r;
  logic               in_config;
  cfd_cnt_t           tec;
  cfd_cnt_t           rec;
  cfd_word_t          evq_ptr_r;
  cfd_word_t          sq_ptr_r;
  cfd_byte_t          fast_tx_r;
  cfd_byte_t          fast_rx_r;
  cfd_byte_t          slow_tx_r;
  cfd_byte_t          slow_rx_r;
  logic [5:0]         flags_r;
  logic [5:0]         flags_nxt;
  logic [`CFD_IRQ_N-1:0] irq_evt;
  logic [`CFD_IRQ_N-1:0] irq_stat;
  logic [`CFD_IRQ_N-1:0] irq_en;
  logic               clr_wr;
  logic               en_wr;
  logic               ctr_clear;
  logic               any_err;

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  assign setup   = psel && !penable;
  assign pready  = 1'b1;
  assign wr_done = psel && penable && pwrite;
  assign addr8   = paddr[7:0];

  always_comb
  begin
    mapped = 1'b1;
    rd_nxt = '0;
    unique case (addr8)
      `CFD_OFF_EVQ_HI:   rd_nxt[15:0] = evq_ptr_r[31:16];
      `CFD_OFF_EVQ_LO:   rd_nxt[15:0] = evq_ptr_r[15:0];
      `CFD_OFF_SQ_HI:    rd_nxt[15:0] = sq_ptr_r[31:16];
      `CFD_OFF_SQ_LO:    rd_nxt[15:0] = sq_ptr_r[15:0];
      `CFD_OFF_FLAGS:    rd_nxt[5:0]  = flags_r;
      `CFD_OFF_COUNTS:   rd_nxt[15:0] = {clip8(tec), clip8(rec)};
      `CFD_OFF_FAST:     rd_nxt[15:0] = {fast_tx_r, fast_rx_r};
      `CFD_OFF_SLOW:     rd_nxt[15:0] = {slow_tx_r, slow_rx_r};
      `CFD_OFF_MODE:     rd_nxt[2:0]  = mode_r;
      `CFD_OFF_IRQ_STAT: rd_nxt[`CFD_IRQ_N-1:0] = irq_stat;
      `CFD_OFF_IRQ_EN:   rd_nxt[`CFD_IRQ_N-1:0] = irq_en;
      `CFD_OFF_IRQ_CLR:  rd_nxt = '0;
      default:           mapped = 1'b0;
    endcase
    if (paddr[AW-1:0] != AW'(addr8))
      mapped = 1'b0;
  end

  // Read data captured in setup so the access phase ends at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= '0;
    else if (setup)
      prdata_r <= pwrite ? '0 : rd_nxt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr_r <= 1'b0;
    else if (setup)
      pslverr_r <= !mapped;
  end

  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  // --------------------------------------------------------------------------
  // Operating mode
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_r <= `CFD_MODE_RST;
    else if (wr_done && (addr8 == `CFD_OFF_MODE) && !pslverr_r && pstrb[0])
      mode_r <= pwdata[2:0];
  end

  assign in_config             = (mode_r == cfd_mode_config);
  assign operating_mode_select = mode_r;

  // --------------------------------------------------------------------------
  // Queue pointers
  // --------------------------------------------------------------------------
  // Sampled every cycle; values during configuration are not meaningful
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evq_ptr_r <= '0;
    else
      evq_ptr_r <= event_queue_tail_in;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sq_ptr_r <= '0;
    else
      sq_ptr_r <= send_queue_head_in;
  end

  // --------------------------------------------------------------------------
  // Main error counters
  // --------------------------------------------------------------------------
  // Off the bus in configuration, so the counts restart from zero
  assign ctr_clear = in_config || recovery_done_pulse;

  cfd_fault_counter
  #(
    .REENTRY_EN (1'b0),
    .FREEZE_EN  (1'b1)
  )
  u_tec
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (ctr_clear),
    .inc_minor (1'b0),
    .inc_major (tx_err_pulse),
    .dec       (tx_ok_pulse),
    .count     (tec)
  );

  cfd_fault_counter
  #(
    .REENTRY_EN (1'b1),
    .FREEZE_EN  (1'b0)
  )
  u_rec
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (ctr_clear),
    .inc_minor (rx_err_pulse),
    .inc_major (rx_err_major_pulse),
    .dec       (rx_ok_pulse),
    .count     (rec)
  );

  // --------------------------------------------------------------------------
  // Error-state flags
  // --------------------------------------------------------------------------
  always_comb
  begin
    flags_nxt = '0;
    flags_nxt[`CFD_FLG_TX_BUS_OFF_FLAG]  = (tec > `CFD_BUSOFF) || in_config;
    flags_nxt[`CFD_FLG_TX_ERROR_PASSIVE_FLAG]  = tec > `CFD_PASSIVE;
    flags_nxt[`CFD_FLG_RX_ERROR_PASSIVE_FLAG]  = rec > `CFD_PASSIVE;
    flags_nxt[`CFD_FLG_TXWRN] = in_warn(tec);
    flags_nxt[`CFD_FLG_RXWRN] = in_warn(rec);
    flags_nxt[`CFD_FLG_EWRN]  = in_warn(tec) || in_warn(rec);
  end

  // Reset lands in configuration, hence bus-off set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_r <= `CFD_FLAGS_RST;
    else
      flags_r <= flags_nxt;
  end

  assign tx_bus_off_flag       = flags_r[`CFD_FLG_TX_BUS_OFF_FLAG];
  assign tx_error_passive_flag = flags_r[`CFD_FLG_TX_ERROR_PASSIVE_FLAG];
  assign rx_error_passive_flag = flags_r[`CFD_FLG_RX_ERROR_PASSIVE_FLAG];
  assign tx_warning_flag       = flags_r[`CFD_FLG_TXWRN];
  assign rx_warning_flag       = flags_r[`CFD_FLG_RXWRN];
  assign any_warning_flag      = flags_r[`CFD_FLG_EWRN];

  // --------------------------------------------------------------------------
  // Phase error counters
  // --------------------------------------------------------------------------
  // A software write wins over a same-cycle count; these are counts, not flags
  // fast-phase transmit and receive
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fast_tx_r <= '0;
      fast_rx_r <= '0;
    end
    else if (wr_done && (addr8 == `CFD_OFF_FAST) && !pslverr_r)
    begin
      fast_tx_r <= strb_byte(fast_tx_r, pwdata[15:8], pstrb[1]);
      fast_rx_r <= strb_byte(fast_rx_r, pwdata[7:0], pstrb[0]);
    end
    else if (fast_phase)
    begin
      if (tx_err_pulse)
        fast_tx_r <= sat_add8(fast_tx_r, `CFD_BYTE_MAJOR);
      if (rx_err_major_pulse)
        fast_rx_r <= sat_add8(fast_rx_r, `CFD_BYTE_MAJOR);
      else if (rx_err_pulse)
        fast_rx_r <= sat_add8(fast_rx_r, `CFD_BYTE_MINOR);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slow_tx_r <= '0;
      slow_rx_r <= '0;
    end
    else if (wr_done && (addr8 == `CFD_OFF_SLOW) && !pslverr_r)
    begin
      slow_tx_r <= strb_byte(slow_tx_r, pwdata[15:8], pstrb[1]);
      slow_rx_r <= strb_byte(slow_rx_r, pwdata[7:0], pstrb[0]);
    end
    else if (!fast_phase)
    begin
      if (tx_err_pulse)
        slow_tx_r <= sat_add8(slow_tx_r, `CFD_BYTE_MAJOR);
      else if (tx_ok_pulse)
        slow_tx_r <= sat_dec8(slow_tx_r);
      if (rx_err_major_pulse)
        slow_rx_r <= sat_add8(slow_rx_r, `CFD_BYTE_MAJOR);
      else if (rx_err_pulse)
        slow_rx_r <= sat_add8(slow_rx_r, `CFD_BYTE_MINOR);
      else if (rx_ok_pulse)
        slow_rx_r <= sat_dec8(slow_rx_r);
    end
  end

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  assign any_err = tx_err_pulse || rx_err_pulse || rx_err_major_pulse;

  // Entry into each warning and passive state, seen as a rising flag, bus-off from the count, plus any error in the fast phase
  always_comb
  begin
    irq_evt = '0;
    irq_evt[`CFD_IRQ_TXWRN]  = flags_nxt[`CFD_FLG_TXWRN] && !flags_r[`CFD_FLG_TXWRN];
    irq_evt[`CFD_IRQ_RXWRN]  = flags_nxt[`CFD_FLG_RXWRN] && !flags_r[`CFD_FLG_RXWRN];
    irq_evt[`CFD_IRQ_TX_ERROR_PASSIVE_FLAG]   = flags_nxt[`CFD_FLG_TX_ERROR_PASSIVE_FLAG] && !flags_r[`CFD_FLG_TX_ERROR_PASSIVE_FLAG];
    irq_evt[`CFD_IRQ_RX_ERROR_PASSIVE_FLAG]   = flags_nxt[`CFD_FLG_RX_ERROR_PASSIVE_FLAG] && !flags_r[`CFD_FLG_RX_ERROR_PASSIVE_FLAG];
    // Configuration entry is not a fault, so only count-driven bus-off fires
    irq_evt[`CFD_IRQ_BO]     = (tec > `CFD_BUSOFF) && !flags_r[`CFD_FLG_TX_BUS_OFF_FLAG];
    irq_evt[`CFD_IRQ_FASTER] = fast_phase && any_err;
  end

  assign clr_wr = wr_done && (addr8 == `CFD_OFF_IRQ_CLR) && !pslverr_r;
  assign en_wr  = wr_done && (addr8 == `CFD_OFF_IRQ_EN) && !pslverr_r;

  cfd_irq_bank
  #(
    .N (`CFD_IRQ_N)
  )
  u_irq
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .evt      (irq_evt),
    .clr_wr   (clr_wr),
    .en_wr    (en_wr),
    .wdata    (pwdata[`CFD_IRQ_N-1:0]),
    .status_r (irq_stat),
    .enable_r (irq_en),
    .irq      (irq)
  );

endmodule // cfd_err_status

// *** verification/cfd_err_status_checker.sv ***
// Purpose: Port-level checks of the error-state block
// Assumes: Zero-wait APB slave, flags registered from the counters
// Notes:   Bound into every instance of the block
`timescale 1ns/1ps
module cfd_err_status_checker
  import cfd_pkg::*;
#(
  parameter int AW = 8
)
(
  // Clock and reset
  input wire logic          pclk,
  input wire logic          presetn,
  // APB
  input wire logic [AW-1:0] paddr,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic [31:0]   prdata,
  input wire logic          pslverr,
  // State
  input wire logic [2:0]    operating_mode_select,
  input wire logic          tx_bus_off_flag,
  input wire logic          tx_error_passive_flag,
  input wire logic          rx_error_passive_flag,
  input wire logic          tx_warning_flag,
  input wire logic          rx_warning_flag,
  input wire logic          any_warning_flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------
  // Error state
  // ----------
  chk_cfg_bus_off: assert property
    ((operating_mode_select == 3'h4) [*2] |-> tx_bus_off_flag)
    else $error("bus-off flag low in configuration");
  chk_cfg_quiet: assert property
    ((operating_mode_select == 3'h4) [*3] |->
      !(tx_error_passive_flag || rx_error_passive_flag || any_warning_flag))
    else $error("state flags set in configuration");
  chk_any_warn: assert property
    (any_warning_flag == (tx_warning_flag || rx_warning_flag))
    else $error("combined warning wrong");
  chk_tx_warn_range: assert property
    (tx_warning_flag && operating_mode_select != 3'h4 |->
      !tx_error_passive_flag && !tx_bus_off_flag)
    else $error("transmit warning above its range");
  chk_rx_warn_range: assert property
    (rx_warning_flag |-> !rx_error_passive_flag)
    else $error("receive warning above its range");
  chk_busoff_passive: assert property
    ((operating_mode_select != 3'h4) [*3] ##0 tx_bus_off_flag |-> tx_error_passive_flag)
    else $error("bus-off without transmit passive");

  // ----------
  // Register access
  // ----------
  chk_upper_zero: assert property
    (psel && !penable |=> prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  chk_data_stands: assert property
    (psel && penable |=> $stable(prdata) && $stable(pslverr))
    else $error("read answer changed before next setup");
  chk_unmapped_err: assert property
    (psel && !penable && paddr > 'h2C |=> pslverr)
    else $error("no error on unmapped address");
  chk_mapped_ok: assert property
    (psel && !penable && paddr <= 'h2C && paddr[1:0] == 2'b00 |=> !pslverr)
    else $error("error on mapped address");
endmodule // cfd_err_status_checker

bind cfd_err_status cfd_err_status_checker #(.AW(AW)) u_chk
(
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .prdata(prdata), .pslverr(pslverr), .operating_mode_select(operating_mode_select),
  .tx_bus_off_flag(tx_bus_off_flag), .tx_error_passive_flag(tx_error_passive_flag),
  .rx_error_passive_flag(rx_error_passive_flag), .tx_warning_flag(tx_warning_flag),
  .rx_warning_flag(rx_warning_flag), .any_warning_flag(any_warning_flag)
);

// *** verification/cfd_bus_node.sv ***
// Purpose: Other bus nodes, seen as protocol events and queue positions
// Assumes: Tasks are called after a clock edge
// Notes:   One idle cycle between pulses, so every pulse counts once
`timescale 1ns/1ps
module cfd_bus_node
  import cfd_pkg::*;
(
  // Clock
  input  wire logic pclk,
  // Protocol events
  output logic      tx_err_pulse,
  output logic      rx_err_pulse,
  output logic      rx_err_major_pulse,
  output logic      tx_ok_pulse,
  output logic      rx_ok_pulse,
  output logic      recovery_done_pulse,
  output logic      fast_phase,
  // Queue positions
  output cfd_word_t tail,
  output cfd_word_t head
);
  logic [5:0] ev;
  assign {recovery_done_pulse, rx_ok_pulse, tx_ok_pulse,
          rx_err_major_pulse, rx_err_pulse, tx_err_pulse} = ev;
  initial
  begin
    ev = 6'h00;
    fast_phase = 1'b0;
    tail = 32'h0000_0000;
    head = 32'h0000_0000;
  end
  task automatic send(input int k, input int n, input logic f);
    for (int i = 0; i < n; i++)
    begin
      @(posedge pclk);
      ev <= 6'h01 << k;
      fast_phase <= f;
      @(posedge pclk);
      ev <= 6'h00;
    end
  endtask
  task automatic set_ptr(input cfd_word_t t, input cfd_word_t h);
    @(posedge pclk);
    tail <= t;
    head <= h;
  endtask
endmodule // cfd_bus_node

// *** verification/tb_cfd_err_status.sv ***
// Purpose: Self-checking bench of the error-state block
// Assumes: APB master polls pready although the slave has no wait states
// Notes:   Reads queue their expectation; a monitor compares
`timescale 1ns/1ps
module tb_cfd_err_status
  import cfd_pkg::*;
;
  logic       pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic       tx_e, rx_e, rx_m, tx_ok, rx_ok, fast, recov;
  logic [7:0] paddr;
  logic [3:0] pstrb;
  logic [2:0] mode;
  logic [5:0] flg;
  cfd_word_t  pwdata, prdata, tail, head, t, h;
  int         fails = 0;
  int         compares = 0;
  int         seed = 32'h320cbb4c;
  cfd_word_t  exp_q[$];
  logic       err_q[$];

  cfd_err_status #(.AW(8)) DUT
  (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_err_pulse(tx_e), .rx_err_pulse(rx_e), .rx_err_major_pulse(rx_m),
    .tx_ok_pulse(tx_ok), .rx_ok_pulse(rx_ok), .fast_phase(fast), .recovery_done_pulse(recov),
    .event_queue_tail_in(tail), .send_queue_head_in(head), .operating_mode_select(mode),
    .tx_bus_off_flag(flg[5]), .tx_error_passive_flag(flg[4]), .rx_error_passive_flag(flg[3]),
    .tx_warning_flag(flg[2]), .rx_warning_flag(flg[1]), .any_warning_flag(flg[0]), .irq(irq)
  );
  cfd_bus_node PN
  (
    .pclk(pclk), .tx_err_pulse(tx_e), .rx_err_pulse(rx_e), .rx_err_major_pulse(rx_m),
    .tx_ok_pulse(tx_ok), .rx_ok_pulse(rx_ok), .recovery_done_pulse(recov),
    .fast_phase(fast), .tail(tail), .head(head)
  );

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp_word(input string nm, input cfd_word_t e, input cfd_word_t s);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cmp_bit(input string nm, input logic e, input logic s);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %b seen %b", nm, e, s);
    end
  endtask
  // Hold the whole request until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input cfd_word_t d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        fails++;
        final_report();
      end
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input cfd_word_t e, input logic er = 1'b0);
    exp_q.push_back(e);
    err_q.push_back(er);
    apb(a, 1'b0, 32'h0000_0000);
  endtask
  task automatic wr(input logic [7:0] a, input cfd_word_t d);
    apb(a, 1'b1, d);
    @(posedge pclk);
  endtask
  task automatic ev(input int k, input int n, input logic f = 1'b0);
    PN.send(k, n, f);
    repeat (3) @(posedge pclk);
  endtask
  task automatic tdone(input string nm);
    $display("test %s done", nm);
  endtask

  always @(posedge pclk)
    if (psel && penable && !pwrite && exp_q.size() > 0)
    begin
      cmp_word("prdata", exp_q.pop_front(), prdata);
      cmp_bit("pslverr", err_q.pop_front(), pslverr);
    end

  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    final_report();
  end

  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h10, 32'h0000_0020);
    rd(8'h14, 32'h0000_0000);
    rd(8'h18, 32'h0000_0000);
    rd(8'h1C, 32'h0000_0000);
    rd(8'h20, 32'h0000_0004);
    cmp_word("mode", 32'h0000_0004, {29'h0, mode});
    rd(8'h24, 32'h0000_0000);
    rd(8'h30, 32'h0000_0000, 1'b1);
    tdone("reset");
    wr(8'h20, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    for (int i = 0; i < 2; i++)
    begin
      t = $random(seed);
      h = $random(seed);
      PN.set_ptr(t, h);
      rd(8'h00, {16'h0000, t[31:16]});
      rd(8'h04, {16'h0000, t[15:0]});
      rd(8'h08, {16'h0000, h[31:16]});
      rd(8'h0C, {16'h0000, h[15:0]});
    end
    tdone("pointers");
    ev(0, 12);
    rd(8'h10, 32'h0000_0005);
    rd(8'h14, 32'h0000_6000);
    rd(8'h1C, 32'h0000_6000);
    ev(0, 4);
    rd(8'h10, 32'h0000_0010);
    ev(3, 1);
    rd(8'h10, 32'h0000_0005);
    rd(8'h14, 32'h0000_7F00);
    ev(0, 1);
    ev(2, 12);
    rd(8'h10, 32'h0000_0013);
    rd(8'h14, 32'h0000_8760);
    ev(4, 1);
    rd(8'h10, 32'h0000_0010);
    rd(8'h1C, 32'h0000_875F);
    ev(0, 16);
    rd(8'h10, 32'h0000_0030);
    rd(8'h14, 32'h0000_FF5F);
    ev(2, 5);
    rd(8'h10, 32'h0000_0038);
    ev(4, 1);
    rd(8'h10, 32'h0000_0033);
    cmp_word("flags", 32'h0000_0033, {26'h0, flg});
    rd(8'h14, 32'h0000_FF77);
    rd(8'h1C, 32'h0000_FF86);
    rd(8'h24, 32'h0000_001F);
    ev(5, 1);
    rd(8'h10, 32'h0000_0000);
    tdone("counters");
    wr(8'h28, 32'h0000_003F);
    cmp_bit("irq", 1'b1, irq);
    wr(8'h2C, 32'h0000_003F);
    cmp_bit("irq", 1'b0, irq);
    wr(8'h28, 32'h0000_0020);
    ev(0, 1, 1'b1);
    ev(1, 1, 1'b1);
    cmp_bit("irq", 1'b1, irq);
    rd(8'h18, 32'h0000_0801);
    rd(8'h14, 32'h0000_0801);
    rd(8'h24, 32'h0000_0020);
    wr(8'h28, 32'h0000_0000);
    cmp_bit("irq", 1'b0, irq);
    wr(8'h28, 32'h0000_0020);
    cmp_bit("irq", 1'b1, irq);
    wr(8'h2C, 32'h0000_0020);
    cmp_bit("irq", 1'b0, irq);
    rd(8'h24, 32'h0000_0000);
    tdone("interrupt");
    wr(8'h18, 32'h0000_A55A);
    rd(8'h18, 32'h0000_A55A);
    pstrb <= 4'h2;
    wr(8'h18, 32'h0000_3C3C);
    pstrb <= 4'hF;
    rd(8'h18, 32'h0000_3C5A);
    t = $random(seed);
    wr(8'h1C, t);
    rd(8'h1C, {16'h0000, t[15:0]});
    wr(8'h14, 32'h0000_FFFF);
    rd(8'h14, 32'h0000_0801);
    wr(8'h30, 32'h0000_FFFF);
    rd(8'h30, 32'h0000_0000, 1'b1);
    tdone("access");
    wr(8'h20, 32'h0000_0004);
    rd(8'h10, 32'h0000_0020);
    rd(8'h14, 32'h0000_0000);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h18, 32'h0000_0000);
    rd(8'h1C, 32'h0000_0000);
    tdone("config");
    repeat (2) @(posedge pclk);
    final_report();
  end
endmodule // tb_cfd_err_status
